// file: core/tw_pkg.sv
// shared constants and types of the two-wire register slave
package tw_pkg;

  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h38;
  localparam int         SEL_HIGH_POS     = 2;
  localparam int         SEL_LOW_POS      = 1;
  localparam logic [7:0] PTR_RESET        = 8'h00;
  localparam logic [3:0] BYTE_LAST        = 4'h7;
  localparam logic [3:0] TX_BITS          = 4'h8;
  localparam int         PTR_WIDTH        = 8;
  localparam int         DATA_WIDTH       = 8;
  localparam int         WR_WIDTH         = PTR_WIDTH + DATA_WIDTH;
  localparam int         WR_DEPTH         = 2;
  localparam int         PIN_COUNT        = 5;
  // pin order {sel_high, sel_low, rst_n, sda, scl}; bus idles high
  localparam logic [4:0] PIN_IDLE         = 5'h07;
  localparam int         PIN_SCL          = 0;
  localparam int         PIN_SDA          = 1;
  localparam int         PIN_RST_N        = 2;
  localparam int         PIN_SEL_LOW      = 3;
  localparam int         PIN_SEL_HIGH     = 4;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK  = 3'b010,
    S_WR   = 3'b011,
    S_RD   = 3'b100,
    S_RACK = 3'b101,
    S_WAIT = 3'b110
  } tw_state_e;

endpackage

// file: core/pin_sync.sv
// two-flop synchronisers for asynchronous pin inputs
module pin_sync
  import tw_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        meta_next[i] = async_in[i];
        sync_next[i] = meta_reg[i];
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          meta_reg[i] <= RESET_VAL[i];
          sync_reg[i] <= RESET_VAL[i];
        end else begin
          meta_reg[i] <= meta_next[i];
          sync_reg[i] <= sync_next[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule

// file: core/write_buffer.sv
// shift-register fifo; head entry is a flop so outputs are registered
module write_buffer
  import tw_pkg::*;
#(
  parameter int WIDTH = WR_WIDTH,
  parameter int DEPTH = WR_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;
  logic [DEPTH:0]   vld_up;
  logic [DEPTH:0]   vld_below;
  logic [DEPTH-1:0] vld_shift;
  logic             pop;
  logic             push;

  // no pass-through when full: keeps in_ready a pure flop function
  assign in_ready  = ~vld_reg[DEPTH-1];
  assign pop       = vld_reg[0] & out_ready;
  assign push      = in_valid & in_ready;
  assign vld_up    = {1'b0, vld_reg};
  assign vld_below = {vld_shift, 1'b1};

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
        vld_shift[i] = pop ? vld_up[i+1] : vld_reg[i];
        mem_next[i]  = (pop && i < DEPTH - 1) ? mem_reg[(i < DEPTH - 1) ? i + 1 : i] : mem_reg[i];
        vld_next[i]  = vld_shift[i];
        if (push && !vld_shift[i] && vld_below[i]) begin
          mem_next[i] = in_data;
          vld_next[i] = 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          vld_reg[i] <= 1'b0;
          mem_reg[i] <= '0;
        end else begin
          vld_reg[i] <= vld_next[i];
          mem_reg[i] <= mem_next[i];
        end
      end
    end
  endgenerate

  assign out_valid = vld_reg[0];
  assign out_data  = mem_reg[0];

endmodule

// file: core/two_wire_register_slave.sv
// two-wire slave port giving a bus master access to byte-wide registers
//
// Contract
// - write starts with address, direction zero; match acks
// - first written byte loads register pointer, acked
// - later write bytes stored at pointer, each acked; here a byte is not acked or stored while the write buffer is full
// - pointer advances after each stored byte
// - start is sda falling, scl high; bus busy
// - stop is sda rising, scl high; ends cycle
// - bytes are eight bits, msb first, plus ack
// - sda changes only while scl low
// - ninth clock: receiver holds sda low to ack
// - sda high in ninth clock means not-acknowledge
// - read sends from pointer, zero if never set
// - address match accepted even without start condition
// - reset pin low restores registers and pointer
// - address 0x38, or pin-selected 0x38 to 0x3e
module two_wire_register_slave
  import tw_pkg::*;
#(
  parameter int WR_FIFO_DEPTH = WR_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  rst_pin_n,
  input  wire logic                  array_select_pin_low,
  input  wire logic                  array_select_pin_high,
  input  wire logic                  address_select_enable,
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output logic      [PTR_WIDTH-1:0]  wr_addr,
  output logic      [DATA_WIDTH-1:0] wr_data,
  output logic      [PTR_WIDTH-1:0]  rd_addr,
  input  wire logic [DATA_WIDTH-1:0] rd_data,
  output logic                       bus_busy,
  output logic                       regs_reset
);

  logic [PIN_COUNT-1:0]  pins_raw, pins_sync;
  logic                  scl_s, sda_s;
  logic                  rst_n_s, core_rst;
  logic                  scl_d_reg, sda_d_reg;
  logic                  scl_rise, scl_fall;
  logic                  start_seen, stop_seen;
  logic [6:0]            dev_addr;
  logic [7:0]            win;
  logic                  addr_hit;

  tw_state_e             state_reg, state_next;
  tw_state_e             after_reg, after_next;
  logic [3:0]            cnt_reg, cnt_next;
  logic [7:0]            shift_reg, shift_next;
  logic [PTR_WIDTH-1:0]  ptr_reg, ptr_next;
  logic [DATA_WIDTH-1:0] tx_reg, tx_next;
  logic                  first_reg, first_next;
  logic                  ack_go_reg, ack_go_next;
  logic                  ack_half_reg, ack_half_next;
  logic                  mack_reg, mack_next;
  logic                  oe_reg, oe_next;
  logic                  busy_reg, busy_next;
  logic                  regs_reset_reg, regs_reset_next;
  logic                  sda_out_reg;
  logic                  push, fifo_in_ready;
  logic [WR_WIDTH-1:0]   fifo_out_data;

  assign pins_raw = {array_select_pin_high, array_select_pin_low, rst_pin_n, sda_in, scl_in};

  pin_sync #(
    .WIDTH     (PIN_COUNT),
    .RESET_VAL (PIN_IDLE)
  ) u_pin_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign scl_s   = pins_sync[PIN_SCL];
  assign sda_s   = pins_sync[PIN_SDA];
  assign rst_n_s = pins_sync[PIN_RST_N];

  // the reset pin clears the pointer and the whole frame state
  assign core_rst = srst | ~rst_n_s;

  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  // sda moving while scl stays high is framing, never data
  assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always_comb begin
    dev_addr = DEV_ADDR_DEFAULT;
    if (address_select_enable) begin
      dev_addr[SEL_HIGH_POS] = pins_sync[PIN_SEL_HIGH];
      dev_addr[SEL_LOW_POS]  = pins_sync[PIN_SEL_LOW];
    end
  end

  // msb arrives first, so the newest bit enters at the bottom
  assign win      = {shift_reg[6:0], sda_s};
  assign addr_hit = (win[7:1] == dev_addr);

  always_comb begin
    state_next    = state_reg;
    after_next    = after_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    ptr_next      = ptr_reg;
    tx_next       = tx_reg;
    first_next    = first_reg;
    ack_go_next   = ack_go_reg;
    ack_half_next = ack_half_reg;
    mack_next     = mack_reg;
    oe_next       = oe_reg;
    busy_next     = busy_reg;
    push          = 1'b0;
    if (start_seen) begin
      state_next    = S_ADDR;
      cnt_next      = 4'h0;
      oe_next       = 1'b0;
      ack_half_next = 1'b0;
      busy_next     = 1'b1;
    end else if (stop_seen) begin
      state_next    = S_IDLE;
      cnt_next      = 4'h0;
      oe_next       = 1'b0;
      ack_half_next = 1'b0;
      busy_next     = 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          // sliding match: any eight bits equal to the address wake us
          if (scl_rise) begin
            shift_next = win;
            if (cnt_reg == BYTE_LAST && addr_hit) begin
              ack_go_next = 1'b1;
              after_next  = win[0] ? S_RD : S_WR;
              first_next  = 1'b1;
              cnt_next    = 4'h0;
              state_next  = S_ACK;
            end else if (cnt_reg != BYTE_LAST) begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        S_ADDR: begin
          if (scl_rise) begin
            shift_next = win;
            if (cnt_reg == BYTE_LAST) begin
              if (addr_hit) begin
                ack_go_next = 1'b1;
                after_next  = win[0] ? S_RD : S_WR;
                first_next  = 1'b1;
                cnt_next    = 4'h0;
                state_next  = S_ACK;
              end else begin
                // window stays full so idle matching keeps sliding
                state_next = S_IDLE;
              end
            end else begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        S_ACK: begin
          // ninth clock: pull low from its leading fall to its trailing fall
          if (scl_fall) begin
            if (!ack_half_reg) begin
              oe_next       = ack_go_reg;
              ack_half_next = 1'b1;
            end else begin
              oe_next       = 1'b0;
              ack_half_next = 1'b0;
              cnt_next      = 4'h0;
              state_next    = after_reg;
              if (after_reg == S_RD) begin
                tx_next  = rd_data;
                oe_next  = ~rd_data[7];
                cnt_next = 4'h1;
              end
            end
          end
        end
        S_WR: begin
          if (scl_rise) begin
            shift_next = win;
            if (cnt_reg == BYTE_LAST) begin
              cnt_next    = 4'h0;
              state_next  = S_ACK;
              ack_go_next = 1'b1;
              after_next  = S_WR;
              if (first_reg) begin
                ptr_next   = win;
                first_next = 1'b0;
              end else if (fifo_in_ready) begin
                push     = 1'b1;
                ptr_next = ptr_reg + 8'h01;
              end else begin
                // buffer full: refuse the byte rather than drop it
                ack_go_next = 1'b0;
                after_next  = S_WAIT;
              end
            end else begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        S_RD: begin
          // bits change only after scl has fallen
          if (scl_fall) begin
            if (cnt_reg == TX_BITS) begin
              oe_next    = 1'b0;
              ptr_next   = ptr_reg + 8'h01;
              cnt_next   = 4'h0;
              state_next = S_RACK;
            end else begin
              tx_next  = {tx_reg[6:0], 1'b0};
              oe_next  = ~tx_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end
          if (scl_fall) begin
            if (mack_reg) begin
              tx_next    = rd_data;
              oe_next    = ~rd_data[7];
              cnt_next   = 4'h1;
              state_next = S_RD;
            end else begin
              oe_next    = 1'b0;
              state_next = S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // parked with sda released until start or stop
          oe_next = 1'b0;
        end
        default: begin
          state_next = S_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_reg    <= S_IDLE;
      after_reg    <= S_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= PTR_RESET;
      tx_reg       <= 8'h00;
      first_reg    <= 1'b0;
      ack_go_reg   <= 1'b0;
      ack_half_reg <= 1'b0;
      mack_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      after_reg    <= after_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      ptr_reg      <= ptr_next;
      tx_reg       <= tx_next;
      first_reg    <= first_next;
      ack_go_reg   <= ack_go_next;
      ack_half_reg <= ack_half_next;
      mack_reg     <= mack_next;
      oe_reg       <= oe_next;
      busy_reg     <= busy_next;
    end
  end

  // register file outside is held in defaults while the pin is low
  always_comb begin
    regs_reset_next = ~rst_n_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regs_reset_reg <= 1'b1;
      sda_out_reg    <= 1'b0;
      // edge history idles high so no false edge follows reset
      scl_d_reg      <= 1'b1;
      sda_d_reg      <= 1'b1;
    end else begin
      regs_reset_reg <= regs_reset_next;
      sda_out_reg    <= 1'b0;
      scl_d_reg      <= scl_s;
      sda_d_reg      <= sda_s;
    end
  end

  // buffer is not flushed by the pin reset: queued writes still land
  write_buffer #(
    .WIDTH (WR_WIDTH),
    .DEPTH (WR_FIFO_DEPTH)
  ) u_write_buffer (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr_reg, win}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out_data)
  );

  assign wr_addr    = fifo_out_data[WR_WIDTH-1:DATA_WIDTH];
  assign wr_data    = fifo_out_data[DATA_WIDTH-1:0];
  assign rd_addr    = ptr_reg;
  assign sda_oe     = oe_reg;
  assign sda_out    = sda_out_reg;
  assign bus_busy   = busy_reg;
  assign regs_reset = regs_reset_reg;

endmodule

// file: dv/tw_slave_sva.sv
// concurrent checks on the ports of the two-wire register slave
module tw_slave_sva
  import tw_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       rst_pin_n,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic       bus_busy,
  input wire logic       regs_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  open_drain_a:
    assert property (sda_out == 1'b0) else $error("sda driven high");
  reset_values_a:
    assert property ($fell(srst) |-> !sda_oe && !wr_valid && !bus_busy && regs_reset && rd_addr == PTR_RESET)
      else $error("outputs not at reset values");
  pin_reset_a:
    assert property ((!rst_pin_n) [*5] |=> regs_reset && rd_addr == PTR_RESET)
      else $error("reset pin did not restore pointer");
  start_busy_a:
    assert property ($past(scl_in) && scl_in && $fell(sda_in) |-> ##[1:6] bus_busy)
      else $error("bus not busy after start");
  stop_free_a:
    assert property ($past(scl_in) && scl_in && $rose(sda_in) |-> ##[1:6] !bus_busy)
      else $error("bus not free after stop");
  write_hold_a:
    assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
      else $error("pending write changed before taken");
  ack_hold_a:
    assert property (sda_oe && $rose(scl_in) |-> sda_oe [*4]) else $error("sda released in high phase");
  ptr_step_a:
    assert property ($rose(wr_valid) |-> ##[0:4] rd_addr == wr_addr + 8'h01)
      else $error("pointer not advanced after store");

  cover property (wr_valid && wr_ready);
  cover property ($rose(bus_busy));
  cover property ($fell(regs_reset));
endmodule

bind two_wire_register_slave tw_slave_sva chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .rst_pin_n(rst_pin_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .bus_busy(bus_busy), .regs_reset(regs_reset));

// file: dv/tw_master.sv
// behavioural bus master driving scl and the master side of sda
module tw_master (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines idle high, also around the reset pin edge
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // only one slave on this segment
  task automatic q();
    repeat (2) @(posedge clk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    q();
    q();
  endtask
  // pull scl low without a start, so a bare bit stream follows
  task automatic clk_low();
    scl <= 1'b0;
    q();
  endtask
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    q();
    scl <= 1'b1;
    q();
    s = sda_line;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

// file: dv/two_wire_register_slave_test.sv
// self-checking bench of the two-wire register slave
module two_wire_register_slave_test
  import tw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, srst = 1, rst_pin_n = 1, sel_lo = 0, sel_hi = 0, sel_en = 0, wr_ready = 0, stall = 0;
  wire         scl, sda_m, sda_line, sda_oe, sda_out, wr_valid, bus_busy, regs_reset;
  wire  [7:0]  wr_addr, wr_data, rd_addr;
  logic [7:0]  rd_data, regs[256], shadow[256], p;
  logic [31:0] rnd = 32'd79;
  logic        ack;
  int          n_errors = 0, checked = 0;

  always #25 clk = ~clk;
  // open drain: either party can only pull the line low
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);
  assign rd_data  = regs[rd_addr];

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] dflt(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction

  // register file stand-in, with a randomly stalling consumer
  always @(posedge clk) begin
    rnd <= xs(rnd);
    wr_ready <= ~stall & rnd[3];
    if (regs_reset) foreach (regs[i]) regs[i] <= dflt(i);
    else if (wr_valid && wr_ready) regs[wr_addr] <= wr_data;
  end

  tw_master m (.clk(clk), .scl(scl), .sda_drv(sda_m), .sda_line(sda_line));
  two_wire_register_slave DUT (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .rst_pin_n(rst_pin_n), .array_select_pin_low(sel_lo), .array_select_pin_high(sel_hi),
    .address_select_enable(sel_en), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .bus_busy(bus_busy), .regs_reset(regs_reset));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic do_write(input logic [6:0] dev, input logic [7:0] ptr, input int n, input int nacc,
                          input logic dev_ack);
    logic [7:0] d;
    m.start();
    m.send_byte({dev, 1'b0}, ack);
    check("address ack", 8'(ack), 8'(dev_ack));
    if (dev_ack) begin
      m.send_byte(ptr, ack);
      check("pointer ack", 8'(ack), 8'h01);
      for (int i = 0; i < n; i++) begin
        d = rnd[15:8];
        m.send_byte(d, ack);
        check("data ack", 8'(ack), 8'(i < nacc));
        if (i < nacc) shadow[8'(ptr + i)] = d;
      end
    end
    m.stop();
  endtask

  task automatic do_read(input logic [7:0] ptr, input int n);
    logic [7:0] b;
    m.start();
    m.send_byte({DEV_ADDR_DEFAULT, 1'b1}, ack);
    check("read address ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i < n - 1, b);
      check("read data", b, shadow[8'(ptr + i)]);
    end
    m.stop();
  endtask

  initial begin
    foreach (shadow[i]) shadow[i] = dflt(i);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    do_read(8'h00, 2);
    $display("default pointer test done");
    repeat (4) begin
      p = rnd[7:0];
      do_write(DEV_ADDR_DEFAULT, p, 3, 3, 1'b1);
      do_write(DEV_ADDR_DEFAULT, p, 0, 0, 1'b1);
      do_read(p, 3);
    end
    $display("write and read back test done");
    // consumer stalled: two bytes fit, the third and fourth are refused and dropped
    stall <= 1'b1;
    p = rnd[7:0];
    repeat (2) @(posedge clk);
    do_write(DEV_ADDR_DEFAULT, p, 4, 2, 1'b1);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    do_write(DEV_ADDR_DEFAULT, p, 0, 0, 1'b1);
    do_read(p, 3);
    $display("full buffer test done");
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} <= 2'(s);
      sel_en <= 1'b1;
      repeat (4) @(posedge clk);
      do_write(7'h38 | 7'(s << 1), 8'(s), 1, 1, 1'b1);
      if (s != 0) do_write(7'h38, 8'h00, 0, 0, 1'b0);
    end
    sel_en <= 1'b0;
    repeat (4) @(posedge clk);
    do_write(7'h3e, 8'h00, 0, 0, 1'b0);
    $display("address select test done");
    m.clk_low();
    m.send_byte({DEV_ADDR_DEFAULT, 1'b0}, ack);
    check("bare address ack", 8'(ack), 8'h01);
    m.send_byte(8'h10, ack);
    check("bare pointer ack", 8'(ack), 8'h01);
    m.stop();
    $display("no-start match test done");
    do_write(DEV_ADDR_DEFAULT, 8'h20, 1, 1, 1'b1);
    repeat (20) @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    foreach (shadow[i]) shadow[i] = dflt(i);
    do_read(8'h00, 2);
    do_write(DEV_ADDR_DEFAULT, 8'h20, 0, 0, 1'b1);
    do_read(8'h20, 1);
    $display("reset pin test done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
